// >>> cc_params.svh
`ifndef CC_PARAMS_SVH
`define CC_PARAMS_SVH
// How it works
// - Fast scan is lone command byte 02.
// - Scan byte packs leads 0,1 per channel.
// - Fast scan ignores the channel select bits.
// - Master toggles select between command and reply.
// - Master clocks at least 1.5 us wait.
// - Two clocks process command, two the data.
// - Master clocks at least two cycles before next frame.
// - Gapped clock needs eight trailing pulses.
// - Write-all loads every channel; others one.
// - Reset pin loads defaults in all channels.
// - Channel reset bit resets that channel only.
// - Clocks keep running during hardware reset; the host holds its shift clock low while in reset.
// - Master waits 256 us after channel reset.
// - Channel starts in standby; activation bit0.
// - Standby keeps registers and leads working.
// - Standby ignores analog input and PCM receive.
// - Loop 1 PCM to PCM; loop 2 converter.
// - Loop 3 sigma-delta; loop 4 PCM side.
// - Analog loop also feeds line data to PCM transmit.
// - Equal time slots loop line side back.
// - Per-channel 16-bit linear encoding option.
// - Bytes go LSB first, fields low byte first.
// - Reply excursion is never decoded as command.

// Command byte layout
`define CC_OP_FAST    8'h02
`define CC_OP_WRITE   2'h1
`define CC_OP_READ    2'h2
`define CC_OP_WALL    2'h3
`define CC_OP_MSB     7
`define CC_OP_LSB     6
`define CC_CH_MSB     1
`define CC_CH_LSB     0
// Channel memory addresses
`define CC_ADR_RST    8'h80
`define CC_ADR_ACT    8'h81
`define CC_ADR_TXS    8'h82
`define CC_ADR_RXS    8'h83
`define CC_ADR_LDIR   8'h9E
`define CC_ADR_LOUT   8'h9F
`define CC_ADR_LEAD   8'hA0
`define CC_ADR_TEST   8'hA1
// Storage slots per channel
`define CC_NREG       7
`define CC_IX_RST     3'h0
`define CC_IX_ACT     3'h1
`define CC_IX_TXS     3'h2
`define CC_IX_RXS     3'h3
`define CC_IX_LDIR    3'h4
`define CC_IX_LOUT    3'h5
`define CC_IX_TEST    3'h6
`define CC_IX_NONE    3'h7
// Field positions and reset values
`define CC_RST_BIT    0
`define CC_ACT_ON     1
`define CC_ACT_PCM    1
`define CC_ACT_BIT    0
`define CC_TEST_LIN   3
`define CC_DEF_LDIR   8'h0C
`define CC_DEF_ZERO   8'h00
`define CC_LB_DIG1    3'h1
`define CC_LB_DIG2    3'h2
`define CC_LB_DIG3    3'h3
`define CC_LB_DIG4    3'h4
`define CC_LB_ANA     3'h5
`define CC_NCH        4
`define CC_NLEAD      6
// Timing
`define CC_SYS_NS     25
`define CC_SCLK_HALF  5
`define CC_SCLK_NS    (2 * `CC_SCLK_HALF * `CC_SYS_NS)
`define CC_WAIT_NS    1500
`define CC_GAP_CYC    (2 + ((`CC_WAIT_NS + `CC_SCLK_NS - 1) / `CC_SCLK_NS) + 2)
`define CC_RTAIL_CYC  8
`define CC_WTAIL_CYC  2
`define CC_SWRST_NS   256000
`define CC_SWRST_CYC  ((`CC_SWRST_NS + `CC_SYS_NS - 1) / `CC_SYS_NS)
// Host register offsets
`define CC_H_CMD      4'h0
`define CC_H_ADDR     4'h1
`define CC_H_WDATA    4'h2
`define CC_H_STAT     4'h3
`define CC_H_RDATA    4'h4
`endif

// >>> cc_pkg.sv
`include "cc_params.svh"
package cc_pkg;
  // Device serial states
  typedef enum logic [1:0] {
    CC_D_IDLE  = 2'h0,
    CC_D_CMD   = 2'h1,
    CC_D_WAIT  = 2'h3,
    CC_D_REPLY = 2'h2
  } cc_dstate_t;
  // Host frame states
  typedef enum logic [2:0] {
    CC_H_IDLE = 3'h0,
    CC_H_SEND = 3'h1,
    CC_H_GAP  = 3'h3,
    CC_H_RECV = 3'h2,
    CC_H_TAIL = 3'h6
  } cc_hstate_t;
  // Whole device state
  typedef struct packed {
    logic [2:0]                          csS;
    logic [2:0]                          ckS;
    logic [2:0]                          diS;
    logic [23:0]                         ldS0;
    logic [23:0]                         ldS1;
    cc_dstate_t                          st;
    logic [2:0]                          bitCnt;
    logic [1:0]                          byteIdx;
    logic [7:0]                          sh;
    logic [7:0]                          cmd;
    logic [7:0]                          addr;
    logic [7:0]                          left;
    logic                                reply;
    logic                                armed;
    logic                                oe;
    logic                                sdo;
    logic [7:0]                          outSh;
    logic [3:0][`CC_NREG-1:0][7:0]       mem;
    logic [3:0]                          pcmTx;
    logic [3:0]                          lineRx;
  } cc_dev_t;
  // Whole host state
  typedef struct packed {
    logic [2:0]  div;
    logic        sclk;
    logic        csN;
    logic        cmdBit;
    logic [1:0]  rpS;
    cc_hstate_t  st;
    logic [31:0] tx;
    logic [5:0]  nBits;
    logic [3:0]  cnt;
    logic [15:0] hold;
    logic        go;
    logic        awaits;
    logic [7:0]  cmdR;
    logic [7:0]  addrR;
    logic [7:0]  wdR;
    logic [7:0]  rx;
    logic [7:0]  rdata;
  } cc_host_t;
endpackage : cc_pkg

// >>> cc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cc_link_if;
  logic csN;       // Chip select, low active
  logic sclk;      // Serial shift clock
  logic cmdBit;    // Master to device data
  logic replyBit;  // Device reply bit
  logic replyOe;   // Device drives reply line
  logic replyLine; // Resolved line, pulled high
  // Pull-up when nobody drives
  assign replyLine = replyOe ? replyBit : 1'b1;
  modport host   (output csN, output sclk, output cmdBit, input replyLine);
  modport device (input csN, input sclk, input cmdBit, output replyBit, output replyOe);
endinterface : cc_link_if
`default_nettype wire

// >>> cc_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "cc_params.svh"
module cc_device (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  cc_link_if.device         link,
  input  wire logic [23:0]  leadIn,
  output logic      [23:0]  leadOut,
  output logic      [23:0]  leadOe,
  input  wire logic [3:0]   pcmRx,
  input  wire logic [3:0]   lineTx,
  output logic      [3:0]   pcmTx,
  output logic      [3:0]   lineRx,
  output logic      [3:0]   active,
  output logic      [3:0]   chanReset,
  output logic      [3:0]   linear16,
  output logic      [11:0]  loopMode
);
  // Reset image: defaults everywhere
  function automatic cc_pkg::cc_dev_t devRst();
    cc_pkg::cc_dev_t r;
    r     = '0;
    r.csS = 3'h7;
    for (int k = 0; k < `CC_NCH; k++)
      r.mem[k][`CC_IX_LDIR] = `CC_DEF_LDIR;
    return r;
  endfunction : devRst

  localparam cc_pkg::cc_dev_t DEV_RST = devRst();

  // Address to storage slot
  function automatic logic [2:0] slotOf(input logic [7:0] a);
    case (a)
      `CC_ADR_RST:  slotOf = `CC_IX_RST;
      `CC_ADR_ACT:  slotOf = `CC_IX_ACT;
      `CC_ADR_TXS:  slotOf = `CC_IX_TXS;
      `CC_ADR_RXS:  slotOf = `CC_IX_RXS;
      `CC_ADR_LDIR: slotOf = `CC_IX_LDIR;
      `CC_ADR_LOUT: slotOf = `CC_IX_LOUT;
      `CC_ADR_TEST: slotOf = `CC_IX_TEST;
      default:      slotOf = `CC_IX_NONE;
    endcase
  endfunction : slotOf

  // Read one location of one channel
  function automatic logic [7:0] rdLoc(input cc_pkg::cc_dev_t s, input logic [1:0] ch,
                                       input logic [7:0] a);
    logic [2:0] ix;
    ix = slotOf(a);
    if (a == `CC_ADR_LEAD)
      rdLoc = {2'h0, s.ldS1[ch*`CC_NLEAD +: `CC_NLEAD]};
    else if (ix == `CC_IX_NONE)
      rdLoc = `CC_DEF_ZERO;
    else
      rdLoc = s.mem[ch][ix];
  endfunction : rdLoc

  cc_pkg::cc_dev_t q;      // Registered state
  cc_pkg::cc_dev_t next_q; // Next state
  logic            csFall; // Select went low
  logic            csRise; // Select went high
  logic            ckRise; // Shift clock rose
  logic            ckFall; // Shift clock fell
  logic [7:0]      byteNow;// Byte completed now
  logic [7:0]      scan;   // Fast scan image
  logic [7:0]      nxtByte;// Next reply byte
  logic [1:0]      op;     // Command operation
  logic [2:0]      ix;     // Target slot
  logic [2:0]      lb;     // Loop mode of channel
  logic            txIn;   // Gated line transmit
  logic            rxIn;   // Gated PCM receive
  logic            same;   // Equal time slots

  // Next-state logic
  always_comb
  begin
    next_q  = q;
    nxtByte = `CC_DEF_ZERO;
    scan    = `CC_DEF_ZERO;
    lb      = 3'h0;
    txIn    = 1'b0;
    rxIn    = 1'b0;
    same    = 1'b0;
    // Two-stage synchronisers plus edge stage
    next_q.csS  = {q.csS[1:0], link.csN};
    next_q.ckS  = {q.ckS[1:0], link.sclk};
    next_q.diS  = {q.diS[1:0], link.cmdBit};
    next_q.ldS0 = leadIn;
    next_q.ldS1 = q.ldS0;
    csFall  = ~q.csS[1] & q.csS[2];
    csRise  = q.csS[1] & ~q.csS[2];
    ckRise  = q.ckS[1] & ~q.ckS[2];
    ckFall  = ~q.ckS[1] & q.ckS[2];
    byteNow = {q.diS[1], q.sh[7:1]};
    op      = q.cmd[`CC_OP_MSB:`CC_OP_LSB];
    ix      = slotOf(q.addr);
    // Scan byte, all four channels
    for (int k = 0; k < `CC_NCH; k++)
    begin
      scan[2*k]   = q.ldS1[k*`CC_NLEAD];
      scan[2*k+1] = q.ldS1[k*`CC_NLEAD + 1];
    end
    case (q.st)
      cc_pkg::CC_D_IDLE:
      begin
        // New command frame
        if (csFall)
        begin
          next_q.st      = cc_pkg::CC_D_CMD;
          next_q.bitCnt  = 3'h0;
          next_q.byteIdx = 2'h0;
          next_q.reply   = 1'b0;
        end
      end
      cc_pkg::CC_D_CMD:
      begin
        // Shift in on rising edge
        if (ckRise && !q.csS[1])
        begin
          next_q.sh     = byteNow;
          next_q.bitCnt = q.bitCnt + 3'h1;
          if (q.bitCnt == 3'h7)
          begin
            if (q.byteIdx != 2'h3)
              next_q.byteIdx = q.byteIdx + 2'h1;
            case (q.byteIdx)
              2'h0:
              begin
                next_q.cmd   = byteNow;
                next_q.reply = (byteNow == `CC_OP_FAST) ||
                               (byteNow[`CC_OP_MSB:`CC_OP_LSB] == `CC_OP_READ);
              end
              2'h1: next_q.addr = byteNow;
              2'h2: next_q.left = byteNow;
              default:
              begin
                // Data bytes of a write
                if (q.left != 8'h00 && (op == `CC_OP_WRITE || op == `CC_OP_WALL))
                begin
                  for (int k = 0; k < `CC_NCH; k++)
                    if (ix != `CC_IX_NONE &&
                        (op == `CC_OP_WALL || q.cmd[`CC_CH_MSB:`CC_CH_LSB] == k[1:0]))
                      next_q.mem[k][ix] = byteNow;
                  next_q.addr = q.addr + 8'h01;
                  next_q.left = q.left - 8'h01;
                end
              end
            endcase
          end
        end
        // Frame end: reply pending only on whole bytes
        if (csRise)
        begin
          next_q.armed = 1'b0;
          next_q.bitCnt = 3'h0;
          if (q.reply && q.bitCnt == 3'h0 &&
              q.byteIdx == ((q.cmd == `CC_OP_FAST) ? 2'h1 : 2'h3))
            next_q.st = cc_pkg::CC_D_WAIT;
          else
            next_q.st = cc_pkg::CC_D_IDLE;
        end
      end
      cc_pkg::CC_D_WAIT:
      begin
        // Two clocks with select high process the command
        if (ckRise && q.csS[1] && !q.armed)
        begin
          next_q.bitCnt = q.bitCnt + 3'h1;
          if (q.bitCnt == 3'h1)
          begin
            next_q.armed = 1'b1;
            if (q.cmd == `CC_OP_FAST)
            begin
              next_q.outSh = scan;
              next_q.left  = 8'h01;
            end
            else
              next_q.outSh = rdLoc(q, q.cmd[`CC_CH_MSB:`CC_CH_LSB], q.addr);
          end
        end
        // Reply excursion; never decoded
        if (csFall)
        begin
          next_q.st     = cc_pkg::CC_D_REPLY;
          next_q.bitCnt = 3'h0;
          next_q.oe     = q.armed && q.left != 8'h00;
          next_q.sdo    = q.outSh[0];
        end
      end
      cc_pkg::CC_D_REPLY:
      begin
        // Shift out on falling edge, LSB first
        if (ckFall && !q.csS[1] && q.oe)
        begin
          next_q.bitCnt = q.bitCnt + 3'h1;
          if (q.bitCnt == 3'h7)
          begin
            nxtByte      = rdLoc(q, q.cmd[`CC_CH_MSB:`CC_CH_LSB], q.addr + 8'h01);
            next_q.addr  = q.addr + 8'h01;
            next_q.left  = q.left - 8'h01;
            next_q.outSh = nxtByte;
            next_q.sdo   = nxtByte[0];
            next_q.oe    = q.left != 8'h01;
          end
          else
          begin
            next_q.outSh = {1'b0, q.outSh[7:1]};
            next_q.sdo   = q.outSh[1];
          end
        end
        // Reply over
        if (csRise)
        begin
          next_q.st = cc_pkg::CC_D_IDLE;
          next_q.oe = 1'b0;
        end
      end
      default: next_q.st = cc_pkg::CC_D_IDLE;
    endcase
    // Per-channel reset, standby and test paths
    for (int k = 0; k < `CC_NCH; k++)
    begin
      // Channel reset keeps time slots, registers stay reachable
      if (q.mem[k][`CC_IX_RST][`CC_RST_BIT])
      begin
        next_q.mem[k][`CC_IX_ACT]  = `CC_DEF_ZERO;
        next_q.mem[k][`CC_IX_LDIR] = `CC_DEF_LDIR;
        next_q.mem[k][`CC_IX_LOUT] = `CC_DEF_ZERO;
        next_q.mem[k][`CC_IX_TEST] = `CC_DEF_ZERO;
      end
      lb   = q.mem[k][`CC_IX_TEST][2:0];
      // Standby blanks analog and PCM inputs
      txIn = q.mem[k][`CC_IX_ACT][`CC_ACT_BIT] & lineTx[k];
      rxIn = q.mem[k][`CC_IX_ACT][`CC_ACT_BIT] & pcmRx[k];
      same = q.mem[k][`CC_IX_ACT][`CC_ACT_PCM] &&
             q.mem[k][`CC_IX_TXS] == q.mem[k][`CC_IX_RXS];
      // PCM transmit: loop 1 returns receive data
      next_q.pcmTx[k] = (lb == `CC_LB_DIG1) ? rxIn : txIn;
      // Line receive: converter and PCM-side loops
      if (lb == `CC_LB_DIG2 || lb == `CC_LB_ANA)
        next_q.lineRx[k] = txIn;
      else if (lb == `CC_LB_DIG3 || lb == `CC_LB_DIG4)
        next_q.lineRx[k] = txIn;
      else if (same)
        next_q.lineRx[k] = txIn;
      else
        next_q.lineRx[k] = rxIn;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      q <= DEV_RST;
    else
      q <= next_q;
  end

  // Outputs straight from state
  assign link.replyBit = q.sdo;
  assign link.replyOe  = q.oe;
  assign pcmTx         = q.pcmTx;
  assign lineRx        = q.lineRx;
  genvar g;
  generate
    for (g = 0; g < `CC_NCH; g++)
    begin : gCh
      assign leadOut[g*`CC_NLEAD +: `CC_NLEAD] = q.mem[g][`CC_IX_LOUT][5:0];
      assign leadOe[g*`CC_NLEAD +: `CC_NLEAD]  = q.mem[g][`CC_IX_LDIR][5:0];
      assign active[g]                         = q.mem[g][`CC_IX_ACT][`CC_ACT_BIT];
      assign chanReset[g]                      = q.mem[g][`CC_IX_RST][`CC_RST_BIT];
      assign linear16[g]                       = q.mem[g][`CC_IX_TEST][`CC_TEST_LIN];
      assign loopMode[g*3 +: 3]                = q.mem[g][`CC_IX_TEST][2:0];
    end
  endgenerate
endmodule : cc_device
`default_nettype wire

// >>> cc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "cc_params.svh"
module cc_host #(
  parameter int SWRST_CYC = `CC_SWRST_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  cc_link_if.host          link,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata
);
  localparam logic [3:0]  GAP_CYC   = 4'(`CC_GAP_CYC);
  localparam logic [3:0]  RTAIL_CYC = 4'(`CC_RTAIL_CYC);
  localparam logic [3:0]  WTAIL_CYC = 4'(`CC_WTAIL_CYC);
  localparam logic [2:0]  HALF_END  = 3'(`CC_SCLK_HALF - 1);
  localparam logic [15:0] HOLD_CYC  = 16'(SWRST_CYC);
  localparam cc_pkg::cc_host_t HOST_RST = '{csN: 1'b1, st: cc_pkg::CC_H_IDLE, default: '0};

  cc_pkg::cc_host_t q;      // Registered state
  cc_pkg::cc_host_t next_q; // Next state
  logic             tick;   // Half period done
  logic             fall;   // Clock falls now
  logic             busy;   // Transfer under way

  // Next-state logic
  always_comb
  begin
    next_q       = q;
    next_q.rdata = 8'h00;
    next_q.rpS   = {q.rpS[0], link.replyLine};
    // Free-running shift clock divider
    tick         = q.div == HALF_END;
    fall         = tick & q.sclk;
    next_q.div   = tick ? 3'h0 : q.div + 3'h1;
    if (tick)
      next_q.sclk = ~q.sclk;
    busy = q.st != cc_pkg::CC_H_IDLE || q.go || q.hold != 16'h0000;
    if (q.hold != 16'h0000)
      next_q.hold = q.hold - 16'h0001;
    // Register writes; command refused while busy
    if (regWr)
    begin
      case (regAddr)
        `CC_H_ADDR:  next_q.addrR = regWdata;
        `CC_H_WDATA: next_q.wdR   = regWdata;
        `CC_H_CMD:
        begin
          if (!busy)
          begin
            next_q.cmdR = regWdata;
            next_q.go   = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Register reads, data next cycle only
    if (regRd)
    begin
      case (regAddr)
        `CC_H_CMD:   next_q.rdata = q.cmdR;
        `CC_H_ADDR:  next_q.rdata = q.addrR;
        `CC_H_WDATA: next_q.rdata = q.wdR;
        `CC_H_STAT:  next_q.rdata = {6'h00, q.hold != 16'h0000, busy};
        `CC_H_RDATA: next_q.rdata = q.rx;
        default:     next_q.rdata = 8'h00;
      endcase
    end
    // Frame sequencer, steps on falling edges
    case (q.st)
      cc_pkg::CC_H_IDLE:
      begin
        if (fall && q.go)
        begin
          next_q.go  = 1'b0;
          next_q.csN = 1'b0;
          next_q.st  = cc_pkg::CC_H_SEND;
          if (q.cmdR == `CC_OP_FAST)
          begin
            next_q.tx     = {24'h000000, q.cmdR};
            next_q.nBits  = 6'd8;
            next_q.awaits = 1'b1;
          end
          else if (q.cmdR[`CC_OP_MSB:`CC_OP_LSB] == `CC_OP_READ)
          begin
            next_q.tx     = {8'h00, 8'h01, q.addrR, q.cmdR};
            next_q.nBits  = 6'd24;
            next_q.awaits = 1'b1;
          end
          else
          begin
            next_q.tx     = {q.wdR, 8'h01, q.addrR, q.cmdR};
            next_q.nBits  = 6'd32;
            next_q.awaits = 1'b0;
          end
          next_q.cmdBit = next_q.tx[0];
        end
      end
      cc_pkg::CC_H_SEND:
      begin
        if (fall)
        begin
          if (q.nBits == 6'd1)
          begin
            next_q.csN    = 1'b1;
            next_q.cmdBit = 1'b0;
            next_q.st     = q.awaits ? cc_pkg::CC_H_GAP : cc_pkg::CC_H_TAIL;
            next_q.cnt    = q.awaits ? GAP_CYC : WTAIL_CYC;
            // Shift register is spent here, so test the held address
            if (!q.awaits && q.addrR == `CC_ADR_RST)
              next_q.hold = HOLD_CYC;
          end
          else
          begin
            next_q.tx     = {1'b0, q.tx[31:1]};
            next_q.cmdBit = q.tx[1];
            next_q.nBits  = q.nBits - 6'd1;
          end
        end
      end
      cc_pkg::CC_H_GAP:
      begin
        // Wait clocks, then reopen select for reply
        if (fall)
        begin
          if (q.cnt == 4'h1)
          begin
            next_q.csN   = 1'b0;
            next_q.st    = cc_pkg::CC_H_RECV;
            next_q.nBits = 6'd8;
          end
          else
            next_q.cnt = q.cnt - 4'h1;
        end
      end
      cc_pkg::CC_H_RECV:
      begin
        // Bit k sampled at fall k+1
        if (fall)
        begin
          next_q.rx    = {q.rpS[1], q.rx[7:1]};
          next_q.nBits = q.nBits - 6'd1;
          if (q.nBits == 6'd1)
          begin
            next_q.csN = 1'b1;
            next_q.st  = cc_pkg::CC_H_TAIL;
            next_q.cnt = RTAIL_CYC;
          end
        end
      end
      cc_pkg::CC_H_TAIL:
      begin
        // Trailing clocks before next frame
        if (fall)
        begin
          if (q.cnt == 4'h1)
            next_q.st = cc_pkg::CC_H_IDLE;
          else
            next_q.cnt = q.cnt - 4'h1;
        end
      end
      default: next_q.st = cc_pkg::CC_H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      q <= HOST_RST;
    else
      q <= next_q;
  end

  // Outputs from state
  assign link.csN    = q.csN;
  assign link.sclk   = q.sclk;
  assign link.cmdBit = q.cmdBit;
  assign regRdata    = q.rdata;
endmodule : cc_host
`default_nettype wire

// >>> cc_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cc_link_chk (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic csN,
  input  wire logic sclk,
  input  wire logic replyBit,
  input  wire logic replyOe
);
  logic [7:0] hiCnt;   // Cycles with select high
  logic [5:0] nBit;    // Clock rises this excursion
  logic [5:0] lastLen; // Rises of last excursion, zero if it carried a reply
  logic       oeSeen;  // Reply driven this excursion
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Measure gaps and excursion lengths
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      hiCnt   <= 8'hFF;
      nBit    <= 6'h00;
      lastLen <= 6'h00;
      oeSeen  <= 1'b0;
    end
    else
    begin
      hiCnt  <= csN ? ((hiCnt == 8'hFF) ? hiCnt : hiCnt + 8'h01) : 8'h00;
      nBit   <= csN ? 6'h00 : nBit + {5'h00, $rose(sclk)};
      oeSeen <= csN ? 1'b0 : (oeSeen | replyOe);
      if ($rose(csN))
        lastLen <= oeSeen ? 6'h00 : nBit;
    end
  AST_OE_OFF: assert property (csN [*6] |-> !replyOe) else $error("reply driven, select high");
  AST_CS_LOW: assert property ($changed(csN) |-> !sclk) else $error("select moved, clock high");
  AST_CLK_HI: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk) else $error("clock high phase");
  AST_GAP: assert property ($fell(csN) |-> hiCnt >= 8'h14) else $error("frame gap short");
  AST_WAIT: assert property ($fell(csN) && (lastLen == 6'h08 || lastLen == 6'h18) |-> hiCnt >= 8'h64)
    else $error("reply wait short");
  AST_BYTES: assert property ($rose(csN) |-> nBit[2:0] == 3'h0) else $error("partial byte");
  AST_STEADY: assert property (replyOe && sclk && $past(sclk) |-> $stable(replyBit))
    else $error("reply moved, clock high");
  AST_ONE: assert property (replyOe |-> nBit <= 6'h08) else $error("reply past one byte");
  AST_START: assert property ($rose(replyOe) |-> !csN && nBit == 6'h00) else $error("late reply");
endmodule : cc_link_chk
`default_nettype wire

// >>> codec_control_special_commands_tb.sv
`timescale 1ns/1ps
`default_nettype none
module codec_control_special_commands_tb;
  logic        sys_clk  = 1'b0;      // 40 MHz clock
  logic        reset    = 1'b1;      // Held at start
  logic [3:0]  regAddr  = 4'h0;      // Host register port
  logic [7:0]  regWdata = 8'h00;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic [7:0]  regRdata;
  logic [23:0] leadIn   = 24'h000000; // Lead pins
  logic [3:0]  pcmRx    = 4'h0;
  logic [3:0]  lineTx   = 4'h0;
  logic [23:0] leadOe;
  logic [23:0] leadOut;              // Lead drive values
  logic [3:0]  pcmTx;                // Looped PCM transmit
  logic [3:0]  lineRx;               // Looped line receive
  logic [3:0]  active;
  logic [3:0]  chanReset;
  logic [3:0]  linear16;
  logic [11:0] loopMode;
  logic [7:0]  d;                    // Last read data
  logic        sawHold;              // Hold flag seen
  int          n_mismatch = 0;
  int          checked    = 0;
  cc_link_if lnk ();
  // Clock
  always #12.5 sys_clk = ~sys_clk;
  cc_device cc_device_i (.sys_clk(sys_clk), .reset(reset), .link(lnk), .leadIn(leadIn), .leadOut(leadOut),
    .leadOe(leadOe), .pcmRx(pcmRx), .lineTx(lineTx), .pcmTx(pcmTx), .lineRx(lineRx), .active(active),
    .chanReset(chanReset), .linear16(linear16), .loopMode(loopMode));
  cc_host #(.SWRST_CYC(20)) cc_host_i (.sys_clk(sys_clk), .reset(reset), .link(lnk), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  cc_link_chk cc_link_chk_i (.sys_clk(sys_clk), .reset(reset), .csN(lnk.csN), .sclk(lnk.sclk),
    .replyBit(lnk.replyBit), .replyOe(lnk.replyOe));
  // Compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  // Register read, data in next cycle
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  // Run one frame, poll until idle
  task automatic frame(input logic [7:0] c, input logic [7:0] a, input logic [7:0] v);
    wr(4'h1, a);
    wr(4'h2, v);
    wr(4'h0, c);
    sawHold = 1'b0;
    d = 8'h01;
    for (int i = 0; i < 3000 && d !== 8'h00; i++)
    begin
      rd(4'h3);
      sawHold = sawHold | d[1];
    end
    chk(d, 8'h00);
  endtask : frame
  // Reset state
  task automatic t_reset;
    chk(active, 4'h0);
    chk(leadOe, {4{6'h0C}});
  endtask : t_reset
  // Scan byte from lead pins
  task automatic t_scan;
    logic [23:0] p [2] = '{24'h003081, 24'hFC0F42};
    logic [7:0]  e;
    foreach (p[j])
    begin
      @(posedge sys_clk);
      leadIn <= p[j];
      for (int k = 0; k < 4; k++)
        e[2*k +: 2] = p[j][6*k +: 2];
      frame(8'h02, 8'h00, 8'h00);
      rd(4'h4);
      chk(d, e);
    end
  endtask : t_scan
  // Broadcast then single-channel access
  task automatic t_wall;
    frame(8'hC0, 8'h81, 8'h01);
    chk(active, 4'hF);
    frame(8'h42, 8'h81, 8'h00);
    chk(active, 4'hB);
    frame(8'h82, 8'h81, 8'h00);
    rd(4'h4);
    chk(d, 8'h00);
    frame(8'h83, 8'h81, 8'h00);
    rd(4'h4);
    chk(d, 8'h01);
  endtask : t_wall
  // Channel reset set then cleared
  task automatic t_chrst;
    frame(8'h41, 8'h9F, 8'h15);
    frame(8'h41, 8'h9E, 8'h3F);
    frame(8'h41, 8'h82, 8'h07);
    chk(leadOut[11:6], 6'h15);
    chk(leadOe[11:6], 6'h3F);
    frame(8'h41, 8'h80, 8'h01);
    chk(sawHold, 1'b1);
    chk(chanReset, 4'h2);
    chk(active, 4'h9);
    frame(8'h41, 8'h80, 8'h00);
    chk(chanReset, 4'h0);
    chk(leadOe, {4{6'h0C}});
    chk(leadOut, 24'h000000);
    frame(8'h81, 8'h82, 8'h00);
    rd(4'h4);
    chk(d, 8'h07);
  endtask : t_chrst
  // Every loop mode plus linear option
  task automatic t_loop;
    @(posedge sys_clk);
    pcmRx <= 4'hC;
    for (int m = 1; m <= 5; m++)
    begin
      frame(8'h43, 8'hA1, 8'h08 | 8'(m));
      chk(loopMode[11:9], m[2:0]);
      chk(linear16, 4'h8);
      chk(pcmTx[3:2], {m == 1, 1'b0});
      chk(lineRx[3:2], {m == 1, 1'b0});
    end
  endtask : t_loop
  // Mid-run hardware reset, then the link again
  task automatic t_hwrst;
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(loopMode, 12'h000);
    chk(linear16, 4'h0);
    chk(active, 4'h0);
    chk(leadOut, 24'h000000);
    chk(leadOe, {4{6'h0C}});
    reset <= 1'b0;
    t_scan();
  endtask : t_hwrst
  // Verdict
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_scan();
    t_wall();
    t_chrst();
    t_loop();
    t_hwrst();
    final_report();
  end
  // Watchdog
  initial
  begin
    #800000;
    n_mismatch++;
    final_report();
  end
endmodule : codec_control_special_commands_tb
`default_nettype wire
